// ---- plsm_cfg.svh ----
// Constants for the receive lane status monitor
`ifndef PLSM_CFG_SVH
`define PLSM_CFG_SVH

`define PLSM_LANES 4
`define PLSM_WORD_W 66
`define PLSM_SPACING_W 16
`define PLSM_SPACING_RST 16'h3fff
`define PLSM_LOCK_GOOD 7'h40
`define PLSM_BAD_MAX 5'h10
`define PLSM_WIN_LEN 7'h40
`define PLSM_REPEAT_MAX 3'h4
`define PLSM_LOOP_W 12
`define PLSM_HDR_DATA 2'h1
`define PLSM_HDR_CTRL 2'h2
`define PLSM_IDLE_TYPE 8'h1e
`define PLSM_MARK_L0 24'h477690
`define PLSM_MARK_L1 24'he6c4f0
`define PLSM_MARK_L2 24'h9b65c5
`define PLSM_MARK_L3 24'h3d79a2
`define PLSM_REG_CTRL 32'h0000_0000
`define PLSM_REG_SPACING 32'h0000_0004
`define PLSM_REG_STATUS 32'h0000_0008
`define PLSM_CTRL_PATTERN 0
`define PLSM_CTRL_RLOOP 1
`define PLSM_RESP_OKAY 2'h0
`define PLSM_RESP_SLVERR 2'h2

`endif

// ---- plsm_pkg.sv ----
// Types shared by the receive lane status monitor
package plsm_pkg;
  typedef enum logic [1:0] {
    PLSM_HUNT = 2'b01,
    PLSM_LOCKED = 2'b10
  } plsm_lock_e;
endpackage : plsm_pkg

// ---- plsm_word_sync.sv ----
// Handshake crossing for a multi-bit configuration word
`timescale 1ns/1ps
module plsm_word_sync #(
  parameter int W = 16,
  parameter logic [W-1:0] RST = '0
) (
  // Source side
  input wire logic src_clk,
  input wire logic src_resetn,
  input wire logic [W-1:0] src_data,
  // Destination side
  input wire logic dst_clk,
  input wire logic dst_resetn,
  output logic [W-1:0] dst_data
);
  logic req_q;
  logic [W-1:0] hold_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic req_s1_q;
  logic req_s2_q;
  logic req_s3_q;

  // Hold stays still until the far side has acknowledged
  always_ff @(posedge src_clk) begin
    if (!src_resetn) begin
      req_q <= 1'b0;
      hold_q <= RST;
    end else if (req_q == ack_s2_q && src_data != hold_q) begin
      hold_q <= src_data;
      req_q <= ~req_q;
    end
  end

  always_ff @(posedge src_clk) begin
    if (!src_resetn) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= req_s3_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  always_ff @(posedge dst_clk) begin
    if (!dst_resetn) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  always_ff @(posedge dst_clk) begin
    if (!dst_resetn) begin
      dst_data <= RST;
    end else if (req_s2_q != req_s3_q) begin
      dst_data <= hold_q;
    end
  end
endmodule : plsm_word_sync

// ---- plsm_idle_scrambler.sv ----
// Scrambled idle test pattern source
`include "plsm_cfg.svh"
`timescale 1ns/1ps
module plsm_idle_scrambler (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pattern
  input wire logic enable,
  output logic [65:0] word
);
  logic [57:0] state_q;

  // Self-synchronising 1 + x^39 + x^58 over the payload bits
  function automatic logic [121:0] scramble(input logic [63:0] din, input logic [57:0] st);
    logic [57:0] s;
    logic [63:0] dout;
    s = st;
    dout = '0;
    for (int i = 0; i < 64; i++) begin
      dout[i] = din[i] ^ s[38] ^ s[57];
      s = {s[56:0], dout[i]};
    end
    return {s, dout};
  endfunction : scramble

  logic [121:0] next;
  assign next = scramble({56'h0, `PLSM_IDLE_TYPE}, state_q);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= 58'h3ff_ffff_ffff_ffff;
      word <= '0;
    end else if (enable) begin
      state_q <= next[121:64];
      word <= {next[63:0], `PLSM_HDR_CTRL};
    end
  end
endmodule : plsm_idle_scrambler

// ---- plsm_top.sv ----
// Receive lane status monitor with test pattern, loopback and register slave
//
// What this block does
// RL1: [RL1] Per-lane parity error pulse on bad signature
// RL2: [RL2] Lock bit set when aligned and marker seen
// RL3: [RL3] Lock error on header loss or no marker
// RL4: [RL4] Pulse when marker spacing differs from setting
// RL5: [RL5] Pulse after four marker errors in row
// RL6: [RL6] Pulse on badly formed marker word
// RL7: [RL7] Reconfiguration clock runs free at setting; here the block has no reconfiguration clock
// RL8: [RL8] Loopback select asynchronous, one field per transceiver
// RL9: [RL9] Test pattern and remote loopback provided
// RL10: [RL10] Test pattern is scrambled idle stream
// RL11: [RL11] Receive and transmit logic kept apart; here the transmit select runs on rx_serdes_clk and rx_resetn
// RL12: [RL12] Interface clock is rate over 128
// RL13: [RL13] Lane logic on recovered clock, data forwarded; here all lanes share the one link clock
// RL14: [RL14] Lane clock is lane rate over 66
// RL15: [RL15] Transmit transceivers share one frequency
// RL16: [RL16] Status high only aligned and not error state
// RL17: [RL17] Lane outputs on link clock, cleared by reset
`include "plsm_cfg.svh"
`timescale 1ns/1ps
module plsm_top (
  // Register clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Link clock and receive reset
  input wire logic rx_serdes_clk,
  input wire logic rx_resetn,
  // Received lanes
  input wire logic [3:0][65:0] rx_lane_word,
  input wire logic [3:0] rx_lane_valid,
  input wire logic lanes_aligned,
  input wire logic high_error_rate_state,
  // Lane status
  output logic [3:0] lane_lock,
  output logic [3:0] lane_lock_error,
  output logic [3:0] marker_interval_error,
  output logic [3:0] marker_repeat_error,
  output logic [3:0] marker_format_error,
  output logic [7:0] parity_error_0,
  output logic [7:0] parity_error_1,
  output logic [7:0] parity_error_2,
  output logic [7:0] parity_error_3,
  output logic pcs_status,
  // Transmit and loopback
  input wire logic [65:0] tx_user_word,
  output logic [65:0] tx_word,
  input wire logic [`PLSM_LOOP_W-1:0] transceiver_loopback_select,
  output logic [`PLSM_LOOP_W-1:0] loopback_select_sync
);
  // Register domain state
  logic aw_hold_q, w_hold_q;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] ctrl_q;
  logic [`PLSM_SPACING_W-1:0] spacing_q;
  logic [8:0] stat_s1_q, stat_s2_q;
  // Link domain state
  logic [`PLSM_SPACING_W-1:0] spacing_link;
  logic [1:0] ctrl_s1_q, ctrl_s2_q;
  logic [`PLSM_LOOP_W-1:0] loop_s1_q;
  logic [65:0] pattern_word;
  logic [3:0][7:0] parity_err_q;
  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : merge_strb
  // Folds a 66-bit word into the eight interleaved parity bits
  function automatic logic [7:0] bip_fold(input logic [65:0] w);
    logic [7:0] p;
    p = '0;
    for (int j = 0; j < 66; j++) begin
      p[j % 8] = p[j % 8] ^ w[j];
    end
    return p;
  endfunction : bip_fold
  // Lane codes as a table; each lane looks only at its own
  localparam logic [3:0][23:0] MARK_CODE = {`PLSM_MARK_L3, `PLSM_MARK_L2,
                                            `PLSM_MARK_L1, `PLSM_MARK_L0};
  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (aw_hold_q && w_hold_q) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (aw_hold_q && w_hold_q) begin
      w_hold_q <= 1'b0;
    end
  end

  // Control and spacing registers; status is read only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
      spacing_q <= `PLSM_SPACING_RST;
    end else if (aw_hold_q && w_hold_q) begin
      if (awaddr_q == `PLSM_REG_CTRL) begin
        ctrl_q <= 2'(merge_strb({30'h0, ctrl_q}, wdata_q, wstrb_q));
      end else if (awaddr_q == `PLSM_REG_SPACING) begin
        spacing_q <= 16'(merge_strb({16'h0, spacing_q}, wdata_q, wstrb_q));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PLSM_RESP_OKAY;
    end else if (aw_hold_q && w_hold_q) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_q == `PLSM_REG_CTRL || awaddr_q == `PLSM_REG_SPACING
          || awaddr_q == `PLSM_REG_STATUS) begin
        s_axi_bresp <= `PLSM_RESP_OKAY;
      end else begin
        s_axi_bresp <= `PLSM_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `PLSM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `PLSM_RESP_OKAY;
      if (s_axi_araddr == `PLSM_REG_CTRL) begin
        s_axi_rdata <= {30'h0, ctrl_q};
      end else if (s_axi_araddr == `PLSM_REG_SPACING) begin
        s_axi_rdata <= {16'h0, spacing_q};
      end else if (s_axi_araddr == `PLSM_REG_STATUS) begin
        s_axi_rdata <= {23'h0, stat_s2_q};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= `PLSM_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Status levels cross bit by bit; each bit is an independent level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_s1_q <= '0;
      stat_s2_q <= '0;
    end else begin
      stat_s1_q <= {pcs_status, lane_lock_error, lane_lock};
      stat_s2_q <= stat_s1_q;
    end
  end

  // Spacing is a word, so it needs a handshake rather than per-bit sync
  plsm_word_sync #(
    .W(`PLSM_SPACING_W),
    .RST(`PLSM_SPACING_RST)
  ) u_spacing_sync (
    .src_clk(aclk),
    .src_resetn(aresetn),
    .src_data(spacing_q),
    .dst_clk(rx_serdes_clk),
    .dst_resetn(rx_resetn),
    .dst_data(spacing_link)
  );

  always_ff @(posedge rx_serdes_clk) begin
    if (!rx_resetn) begin
      ctrl_s1_q <= '0;
      ctrl_s2_q <= '0;
      loop_s1_q <= '0;
      loopback_select_sync <= '0;
    end else begin
      ctrl_s1_q <= ctrl_q;
      ctrl_s2_q <= ctrl_s1_q;
      loop_s1_q <= transceiver_loopback_select; // [RL8]
      loopback_select_sync <= loop_s1_q;
    end
  end

  plsm_idle_scrambler u_pattern (
    .clk(rx_serdes_clk),
    .resetn(rx_resetn),
    .enable(ctrl_s2_q[`PLSM_CTRL_PATTERN]),
    .word(pattern_word)
  );

  // Transmit select: pattern wins over remote loopback
  always_ff @(posedge rx_serdes_clk) begin
    if (!rx_resetn) begin
      tx_word <= '0;
    end else if (ctrl_s2_q[`PLSM_CTRL_PATTERN]) begin
      tx_word <= pattern_word; // [RL9] [RL10]
    end else if (ctrl_s2_q[`PLSM_CTRL_RLOOP]) begin
      tx_word <= rx_lane_word[0]; // [RL9]
    end else begin
      tx_word <= tx_user_word;
    end
  end
  always_ff @(posedge rx_serdes_clk) begin
    if (!rx_resetn) begin
      pcs_status <= 1'b0;
    end else begin
      pcs_status <= lanes_aligned && !high_error_rate_state; // [RL16]
    end
  end
  assign parity_error_0 = parity_err_q[0];
  assign parity_error_1 = parity_err_q[1];
  assign parity_error_2 = parity_err_q[2];
  assign parity_error_3 = parity_err_q[3];
  // Per-lane monitor; all lanes share the one link clock here [RL11] [RL13]
  for (genvar i = 0; i < `PLSM_LANES; i++) begin : g_lane
    plsm_pkg::plsm_lock_e state_q;
    logic [6:0] good_cnt_q, win_cnt_q;
    logic [4:0] bad_cnt_q;
    logic seen_q, lost_q;
    logic [`PLSM_SPACING_W-1:0] cnt_q;
    logic [2:0] rep_q;
    logic [7:0] bip_q;
    logic [65:0] w;
    logic sh_ok, is_mark, fmt_bad, gap_bad, mark_err;
    assign w = rx_lane_word[i];
    assign sh_ok = w[1:0] == `PLSM_HDR_DATA || w[1:0] == `PLSM_HDR_CTRL;
    assign is_mark = state_q == plsm_pkg::PLSM_LOCKED && rx_lane_valid[i]
                     && w[1:0] == `PLSM_HDR_CTRL && w[25:2] == MARK_CODE[i];
    assign fmt_bad = is_mark && (w[57:34] != ~w[25:2] || w[65:58] != ~w[33:26]);
    // Late marker counts as well as an early one
    assign gap_bad = seen_q && state_q == plsm_pkg::PLSM_LOCKED && rx_lane_valid[i]
                     && (is_mark ? cnt_q != spacing_link : cnt_q == spacing_link);
    assign mark_err = gap_bad || fmt_bad;
    // Header lock: 64 good to lock, 16 bad in a 64-word window to drop
    always_ff @(posedge rx_serdes_clk) begin
      if (!rx_resetn) begin
        state_q <= plsm_pkg::PLSM_HUNT;
        good_cnt_q <= '0;
        win_cnt_q <= '0;
        bad_cnt_q <= '0;
      end else if (rx_lane_valid[i]) begin
        case (state_q)
          plsm_pkg::PLSM_HUNT: begin
            good_cnt_q <= sh_ok ? good_cnt_q + 7'h1 : 7'h0;
            win_cnt_q <= '0;
            bad_cnt_q <= '0;
            if (sh_ok && good_cnt_q == `PLSM_LOCK_GOOD - 7'h1) begin
              state_q <= plsm_pkg::PLSM_LOCKED;
            end
          end
          plsm_pkg::PLSM_LOCKED: begin
            good_cnt_q <= '0;
            win_cnt_q <= (win_cnt_q == `PLSM_WIN_LEN - 7'h1) ? 7'h0 : win_cnt_q + 7'h1;
            if (!sh_ok && bad_cnt_q == `PLSM_BAD_MAX - 5'h1) begin
              state_q <= plsm_pkg::PLSM_HUNT;
            end else if (win_cnt_q == `PLSM_WIN_LEN - 7'h1) begin
              bad_cnt_q <= '0;
            end else if (!sh_ok) begin
              bad_cnt_q <= bad_cnt_q + 5'h1;
            end
          end
          default: begin
            state_q <= plsm_pkg::PLSM_HUNT;
          end
        endcase
      end
    end
    // Marker tracking and lock levels
    always_ff @(posedge rx_serdes_clk) begin
      if (!rx_resetn) begin
        seen_q <= 1'b0;
        lost_q <= 1'b0;
        cnt_q <= '0;
        lane_lock[i] <= 1'b0;
        lane_lock_error[i] <= 1'b0;
      end else begin
        if (state_q != plsm_pkg::PLSM_LOCKED) begin
          seen_q <= 1'b0;
          cnt_q <= '0;
        end else if (is_mark || gap_bad) begin
          seen_q <= seen_q || is_mark;
          cnt_q <= '0;
        end else if (rx_lane_valid[i] && cnt_q != {`PLSM_SPACING_W{1'b1}}) begin
          cnt_q <= cnt_q + 16'h1;
        end
        if (state_q == plsm_pkg::PLSM_LOCKED && rx_lane_valid[i] && !sh_ok
            && bad_cnt_q == `PLSM_BAD_MAX - 5'h1) begin
          lost_q <= 1'b1;
        end else if (state_q == plsm_pkg::PLSM_LOCKED && seen_q) begin
          lost_q <= 1'b0; // Held until the lane locks again with a marker
        end
        lane_lock[i] <= state_q == plsm_pkg::PLSM_LOCKED && seen_q; // [RL2]
        lane_lock_error[i] <= lost_q || (state_q == plsm_pkg::PLSM_LOCKED && !seen_q
                               && cnt_q == {`PLSM_SPACING_W{1'b1}}); // [RL3]
      end
    end
    // Error pulses, one link clock each [RL17]
    always_ff @(posedge rx_serdes_clk) begin
      if (!rx_resetn) begin
        rep_q <= '0;
        bip_q <= '0;
        parity_err_q[i] <= '0;
        marker_interval_error[i] <= 1'b0;
        marker_format_error[i] <= 1'b0;
        marker_repeat_error[i] <= 1'b0;
      end else begin
        marker_interval_error[i] <= gap_bad; // [RL4]
        marker_format_error[i] <= fmt_bad; // [RL6]
        marker_repeat_error[i] <= mark_err && rep_q == `PLSM_REPEAT_MAX - 3'h1; // [RL5]
        if (mark_err) begin
          rep_q <= (rep_q == `PLSM_REPEAT_MAX - 3'h1) ? 3'h0 : rep_q + 3'h1;
        end else if (is_mark) begin
          rep_q <= '0;
        end
        parity_err_q[i] <= '0;
        if (is_mark) begin
          parity_err_q[i] <= seen_q ? bip_q ^ w[33:26] : 8'h0; // [RL1]
          bip_q <= '0;
        end else if (rx_lane_valid[i]) begin
          bip_q <= bip_q ^ bip_fold(w);
        end
      end
    end
  end
endmodule : plsm_top

// ---- plsm_checker_assertions.sv ----
// Port-level checks for the receive lane status monitor
`timescale 1ns/1ps
module plsm_checker (
  // Link clock and reset
  input wire logic rx_serdes_clk,
  input wire logic rx_resetn,
  // Received lanes
  input wire logic [3:0][65:0] rx_lane_word,
  input wire logic [3:0] rx_lane_valid,
  input wire logic lanes_aligned,
  input wire logic high_error_rate_state,
  // Lane status
  input wire logic [3:0] lane_lock,
  input wire logic [3:0] lane_lock_error,
  input wire logic [3:0] marker_interval_error,
  input wire logic [3:0] marker_repeat_error,
  input wire logic [3:0] marker_format_error,
  input wire logic [7:0] parity_error_0,
  input wire logic [7:0] parity_error_1,
  input wire logic pcs_status
);
  par_cause_a:
    assert property (@(posedge rx_serdes_clk) disable iff (!rx_resetn)
      parity_error_0 != 8'h00 |-> $past(rx_lane_valid[0]) && $past(rx_lane_word[0][1:0]) == 2'h2)
    else $error("parity pulse without a marker word");
  par_one_a:
    assert property (@(posedge rx_serdes_clk) disable iff (!rx_resetn)
      parity_error_1 != 8'h00 |=> parity_error_1 == 8'h00)
    else $error("parity pulse longer than one cycle");
  lock_rise_a:
    assert property (@(posedge rx_serdes_clk) disable iff (!rx_resetn)
      $rose(lane_lock[0]) |-> $past(rx_lane_valid[0], 2)
      && $past(rx_lane_word[0][1:0], 2) == 2'h2)
    else $error("lock rose without a marker word");
  intv_cause_a:
    assert property (@(posedge rx_serdes_clk) disable iff (!rx_resetn)
      (marker_interval_error & ~$past(rx_lane_valid)) == 4'h0)
    else $error("interval pulse without a word");
  rep_one_a:
    assert property (@(posedge rx_serdes_clk) disable iff (!rx_resetn)
      marker_repeat_error != 4'h0 |->
      (marker_repeat_error & ~(marker_format_error | marker_interval_error)) == 4'h0
      ##1 marker_repeat_error == 4'h0)
    else $error("repeat pulse not tied to an error");
  fmt_cause_a:
    assert property (@(posedge rx_serdes_clk) disable iff (!rx_resetn)
      (marker_format_error & ~$past(rx_lane_valid)) == 4'h0)
    else $error("format pulse without a word");
  status_lvl_a:
    assert property (@(posedge rx_serdes_clk) disable iff (!rx_resetn)
      $past(rx_resetn) |-> pcs_status == $past(lanes_aligned && !high_error_rate_state))
    else $error("status level wrong");
  rst_zero_a:
    assert property (@(posedge rx_serdes_clk)
      !rx_resetn |=> {lane_lock, lane_lock_error, marker_format_error, pcs_status} == 13'h0)
    else $error("status not cleared by reset");
endmodule : plsm_checker

bind plsm_top plsm_checker plsm_checker_i (.*);

// ---- plsm_lane_src.sv ----
// Behavioural transceiver lanes feeding the monitor
`include "plsm_cfg.svh"
`timescale 1ns/1ps
module plsm_lane_src (
  // Link clock
  input wire logic clk,
  // Lane words, 66 bits each
  output logic [3:0][65:0] word,
  output logic [3:0] valid
);
  localparam logic [3:0][23:0] CODE = {`PLSM_MARK_L3, `PLSM_MARK_L2, `PLSM_MARK_L1, `PLSM_MARK_L0};
  logic [3:0][7:0] acc_q = '0;
  initial begin
    word = '0;
    valid = '0;
  end
  // Idle lanes show a changing pattern so no stale word looks valid
  task automatic data(input logic [3:0][65:0] w, input logic [3:0] v);
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      word[i] <= v[i] ? w[i] : ~word[i];
      for (int j = 0; j < 66; j++)
        if (v[i]) acc_q[i][j % 8] ^= w[i][j];
    end
    valid <= v;
  endtask : data
  // Marker; parity and complement byte broken only on request
  task automatic mark(input logic [3:0][7:0] pf, input logic [3:0] ff);
    logic [7:0] b;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      b = acc_q[i] ^ pf[i];
      word[i] <= {~b ^ {7'h0, ff[i]}, ~CODE[i], b, CODE[i], `PLSM_HDR_CTRL};
      acc_q[i] = 8'h00;
    end
    valid <= 4'hf;
  endtask : mark
endmodule : plsm_lane_src

// ---- plsm_top_tb_top.sv ----
// Self-checking bench for the receive lane status monitor
`include "plsm_cfg.svh"
`timescale 1ns/1ps
module plsm_top_tb_top;
  logic aclk = 0, aresetn = 0, rx_serdes_clk = 0, rx_resetn = 0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pcs_status, lanes_aligned = 1, high_error_rate_state = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb = 4'hf, lane_lock, lane_lock_error, marker_interval_error;
  logic [3:0] marker_repeat_error, marker_format_error, rx_lane_valid;
  logic [7:0] parity_error_0, parity_error_1, parity_error_2, parity_error_3;
  logic [3:0][65:0] rx_lane_word, w;
  logic [65:0] tx_user_word = '0, tx_word, t;
  logic [`PLSM_LOOP_W-1:0] transceiver_loopback_select = '0, loopback_select_sync;
  logic [33:0] bq[$];
  logic [43:0] pq[$];
  logic [31:0] seed = 32'hbfe1;
  int n_fail = 0, samples_checked = 0;
  wire logic [43:0] ev = {marker_interval_error, marker_repeat_error, marker_format_error,
    parity_error_0, parity_error_1, parity_error_2, parity_error_3};

  plsm_top plsm_top_i (.*);
  plsm_lane_src plsm_lane_src_i (.clk(rx_serdes_clk), .word(rx_lane_word), .valid(rx_lane_valid));

  initial forever #5 aclk = ~aclk; // Free-running system clock
  // Lanes, core and transmit share one link clock, unrelated in phase
  initial begin
    #3;
    forever #40 rx_serdes_clk = ~rx_serdes_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic summarize();
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic err(input string m);
    n_fail++;
    $display("[ERR] %0t %s", $time, m);
  endtask : err

  task automatic chk(input logic ok);
    samples_checked++;
    if (ok !== 1'b1) err("direct compare failed");
  endtask : chk

  task automatic to();
    err("wait timed out");
    summarize();
  endtask : to

  task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
    int n;
    @(posedge aclk);
    bq.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 0;
    if (n == 99) to();
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    int n;
    @(posedge aclk);
    bq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 0;
    if (n == 99) to();
  endtask : rd

  // Random gaps between words model a slow far side
  task automatic per(input int n, input logic bad);
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 4; i++) w[i] = {rnd(), rnd(), (bad && i == 2) ? 2'h0 : `PLSM_HDR_DATA};
      if (rnd() % 4 == 0) plsm_lane_src_i.data(w, 4'h0);
      plsm_lane_src_i.data(w, 4'hf);
    end
    plsm_lane_src_i.data(w, 4'h0);
  endtask : per

  task automatic mk(input logic [3:0][7:0] pf, input logic [3:0] ff, iv, rp);
    if ({pf, ff, iv, rp} != 0) pq.push_back({iv, rp, ff, pf[0], pf[1], pf[2], pf[3]});
    plsm_lane_src_i.mark(pf, ff);
    plsm_lane_src_i.data(w, 4'h0);
  endtask : mk

  always @(posedge aclk) begin
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
      samples_checked++;
      if (bq.size() == 0 || bq[0] !== (s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}))
        err("bus answer mismatch");
      if (bq.size() != 0) void'(bq.pop_front());
    end
  end

  always @(negedge rx_serdes_clk) begin
    if (rx_resetn && ev !== 44'h0) begin
      samples_checked++;
      if (pq.size() == 0 || pq[0] !== ev) err("lane event mismatch");
      if (pq.size() != 0) void'(pq.pop_front());
    end
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    repeat (10) @(posedge rx_serdes_clk);
    rx_resetn <= 1;
    wr(`PLSM_REG_SPACING, 32'h40, `PLSM_RESP_OKAY);
    wr(`PLSM_REG_STATUS, 32'hffff_ffff, `PLSM_RESP_OKAY);
    wr(32'h0000_0040, 32'h1, `PLSM_RESP_SLVERR);
    rd(`PLSM_REG_SPACING, {`PLSM_RESP_OKAY, 32'h0000_0040});
    rd(32'h0000_0040, {`PLSM_RESP_SLVERR, 32'h0});
    rd(`PLSM_REG_STATUS, {`PLSM_RESP_OKAY, 32'h0000_0100});
    w = {4{66'h101}};
    repeat (70) plsm_lane_src_i.data(w, 4'hf);
    mk('0, 4'h0, 4'h0, 4'h0);
    per(64, 0);
    rd(`PLSM_REG_STATUS, {`PLSM_RESP_OKAY, 32'h0000_010f});
    mk({8'hff, 8'h3c, 8'h80, 8'h01}, 4'h0, 4'h0, 4'h0);
    per(64, 0);
    mk('0, 4'h5, 4'h0, 4'h0);
    per(10, 0);
    mk('0, 4'h0, 4'hf, 4'h0);
    per(64, 0);
    mk('0, 4'hf, 4'h0, 4'h0);
    per(64, 0);
    mk('0, 4'hf, 4'h0, 4'h5);
    per(64, 0);
    mk('0, 4'h0, 4'h0, 4'h0);
    per(64, 0);
    mk('0, 4'hf, 4'h0, 4'h0);
    wr(`PLSM_REG_CTRL, 32'h1, `PLSM_RESP_OKAY);
    repeat (8) @(posedge rx_serdes_clk);
    @(negedge rx_serdes_clk);
    t = tx_word;
    @(negedge rx_serdes_clk);
    chk(t[1:0] === `PLSM_HDR_CTRL && tx_word !== t);
    wr(`PLSM_REG_CTRL, 32'h2, `PLSM_RESP_OKAY);
    repeat (8) @(posedge rx_serdes_clk);
    repeat (4) begin
      plsm_lane_src_i.data(w, 4'h0);
      @(negedge rx_serdes_clk);
      t = rx_lane_word[0];
      @(negedge rx_serdes_clk);
      chk(tx_word === t);
    end
    wr(`PLSM_REG_CTRL, 32'h0, `PLSM_RESP_OKAY);
    tx_user_word <= {rnd(), rnd(), 2'h1};
    transceiver_loopback_select <= 12'(rnd());
    high_error_rate_state <= 1;
    repeat (8) @(posedge rx_serdes_clk);
    @(negedge rx_serdes_clk);
    chk(tx_word === tx_user_word);
    chk(loopback_select_sync === transceiver_loopback_select);
    per(40, 1);
    repeat (4) @(posedge rx_serdes_clk);
    rd(`PLSM_REG_STATUS, {`PLSM_RESP_OKAY, 32'h0000_004b});
    chk(pq.size() == 0);
    summarize();
  end
endmodule : plsm_top_tb_top
